// [src/blh_bool_holder.sv]
// One-bit Boolean holder with selectable capture and a delay flag
//
// Function
// R1: Holds one Boolean bit and drives it on the output all the time.
// R2: Startup loads the configured initial value before any capture.
// R3: High mode stores data every cycle the latch control is one.
// R4: Low mode stores data every cycle the latch control is zero.
// R5: An unconnected latch control reads as constant zero.
// R6: Rising mode stores data only on a zero-to-one latch change.
// R7: Falling mode stores data only on a one-to-zero latch change.
// R8: Both mode stores data on any latch change.
// R9: Wide data becomes one if nonzero, zero only if exactly zero.
// R10: With retention on, the stored bit survives power loss and returns.
// R11: Initial source choice applies only with retention, after a download.
// R12: The flag shows its input from one cycle earlier.
// R13: Flag input and output are single bits.
// R14: Users place a flag in every feedback path between blocks.
// R15: Edges compare this cycle's latch with last cycle's registered value.
`timescale 1ns/1ps
`default_nettype none
`include "blh_defs.svh"

module blh_bool_holder
	import blh_pkg::*;
#(
	parameter int DATA_W = `BLH_DATA_W
)(
	input  wire logic       sys_clk,
	input  wire logic       reset_n,
	input  wire blh_cfg_t   cfg_in,
	input  wire blh_data_t  capture_data_in,
	input  wire blh_latch_t latch_in,
	input  wire logic       retained_value_in,
	input  wire logic       flag_in,
	output var  logic       bool_holder_out,
	output var  logic       retain_store_out,
	output var  logic       capture_strobe_out,
	output var  logic       holder_ready_out,
	output var  logic       delayed_bool_out
);

	// The packed carrier fixes the width, so the parameter may not stray
	if (DATA_W != `BLH_DATA_W) begin : g_bad_width
		$error("blh_bool_holder: DATA_W must equal the package width");
	end
	// A float needs its sign bit above the magnitude field
	if (`BLH_FLOAT_MAG_MSB >= DATA_W - 1) begin : g_bad_msb
		$error("blh_bool_holder: float magnitude must leave a sign bit");
	end

	// Nonzero test; a float's sign bit alone still means zero
	function automatic logic to_bool(input blh_data_t d);
		logic r;
		r = 1'h0;
		if (d.is_float) begin
			r = |d.value[`BLH_FLOAT_MAG_MSB:0];
		end else begin
			r = |d.value;
		end
		return r;
	endfunction : to_bool

	function automatic logic take_sample(input blh_mode_t m,
	                                     input logic now,
	                                     input logic prev);
		logic t;
		t = 1'h0;
		unique case (m)
			BLH_MODE_HIGH: t = now;
			BLH_MODE_LOW:  t = !now;
			BLH_MODE_RISE: t = now && !prev;
			BLH_MODE_FALL: t = !now && prev;
			BLH_MODE_BOTH: t = now != prev;
			default:       t = 1'h0;
		endcase
		return t;
	endfunction : take_sample

	blh_state_t state_r;
	blh_state_t state_nxt;
	logic       hold_r;
	logic       hold_nxt;
	logic       latch_prev_r;
	logic       latch_prev_nxt;
	logic       strobe_r;
	logic       strobe_nxt;
	logic       ready_r;
	logic       ready_nxt;
	logic       latch_now;
	logic       data_bool;
	logic       boot_value;
	logic       capture;

	always_comb begin
		// Floating latch input is tied low rather than left to chance
		latch_now = latch_in.connected ? latch_in.level
		                               : `BLH_LATCH_OPEN; // [R5]
		data_bool = to_bool(capture_data_in); // [R9]
		// Retained value wins unless a fresh download asks for the
		// project value; without retention the project value is used
		boot_value = cfg_in.init_value; // [R2]
		if (cfg_in.retain_en) begin
			if (!cfg_in.new_download || cfg_in.init_from_retained) begin
				boot_value = retained_value_in; // [R10] [R11]
			end
		end
		capture = take_sample(cfg_in.mode, latch_now,
		                      latch_prev_r); // [R3] [R4] [R6] [R7] [R8] [R15]
	end

	always_comb begin
		state_nxt      = state_r;
		hold_nxt       = hold_r;
		latch_prev_nxt = latch_now; // [R15]
		strobe_nxt     = 1'h0;
		ready_nxt      = ready_r;
		unique case (state_r)
			BLH_ST_BOOT: begin
				// Config is sampled after release, never under reset
				hold_nxt  = boot_value; // [R2]
				ready_nxt = 1'h1;
				state_nxt = BLH_ST_RUN;
			end
			BLH_ST_RUN: begin
				if (capture) begin
					hold_nxt   = data_bool; // [R3] [R4] [R6] [R7] [R8]
					strobe_nxt = 1'h1;
				end
			end
			default: begin
				state_nxt = BLH_ST_BOOT;
				ready_nxt = 1'h0;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r      <= BLH_ST_BOOT;
			hold_r       <= `BLH_HOLD_RST;
			latch_prev_r <= `BLH_LATCH_OPEN;
			strobe_r     <= 1'h0;
			ready_r      <= 1'h0;
		end else begin
			state_r      <= state_nxt;
			hold_r       <= hold_nxt;
			latch_prev_r <= latch_prev_nxt;
			strobe_r     <= strobe_nxt;
			ready_r      <= ready_nxt;
		end
	end

	// Output copies live in their own flops so each port is registered
	logic out_nxt;
	logic store_nxt;

	always_comb begin
		out_nxt   = hold_nxt; // [R1]
		store_nxt = cfg_in.retain_en ? hold_nxt
		                             : retain_store_out; // [R10]
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			bool_holder_out  <= `BLH_HOLD_RST;
			retain_store_out <= `BLH_HOLD_RST;
		end else begin
			bool_holder_out  <= out_nxt; // [R1]
			retain_store_out <= store_nxt;
		end
	end

	always_comb begin
		capture_strobe_out = strobe_r;
		holder_ready_out   = ready_r;
	end

	// Feedback paths go through this flag so no loop closes combinationally
	blh_flag u_flag (
		.sys_clk          (sys_clk),
		.reset_n          (reset_n),
		.flag_in          (flag_in),
		.delayed_bool_out (delayed_bool_out) // [R12]
	);

endmodule : blh_bool_holder
`default_nettype wire

// [src/blh_defs.svh]
// Constants for the Boolean holder and its delay flag
`ifndef BLH_DEFS_SVH
`define BLH_DEFS_SVH

`define BLH_DATA_W        32
`define BLH_FLOAT_MAG_MSB 30
`define BLH_HOLD_RST      1'h0
`define BLH_FLAG_RST      1'h0
`define BLH_LATCH_OPEN    1'h0
`define BLH_BOOT_CYCLES   1

`endif

// [src/blh_pkg.sv]
// Types shared by the Boolean holder and its delay flag
`include "blh_defs.svh"

package blh_pkg;

	typedef enum logic [4:0] {
		BLH_MODE_HIGH = 5'h01,
		BLH_MODE_LOW  = 5'h02,
		BLH_MODE_RISE = 5'h04,
		BLH_MODE_FALL = 5'h08,
		BLH_MODE_BOTH = 5'h10
	} blh_mode_t;

	typedef enum logic [1:0] {
		BLH_ST_BOOT = 2'h1,
		BLH_ST_RUN  = 2'h2
	} blh_state_t;

	typedef struct packed {
		logic [`BLH_DATA_W-1:0] value;
		logic                   is_float;
	} blh_data_t;

	typedef struct packed {
		blh_mode_t mode;
		logic      init_value;
		logic      retain_en;
		logic      new_download;
		logic      init_from_retained;
	} blh_cfg_t;

	typedef struct packed {
		logic level;
		logic connected;
	} blh_latch_t;

endpackage : blh_pkg

// [src/blh_flag.sv]
// One-cycle delay flag for breaking feedback loops
`timescale 1ns/1ps
`default_nettype none
`include "blh_defs.svh"

module blh_flag
	import blh_pkg::*;
(
	input  wire logic sys_clk,
	input  wire logic reset_n,
	input  wire logic flag_in,
	output var  logic delayed_bool_out
);

	logic flag_nxt;

	always_comb begin
		flag_nxt = flag_in; // [R12] [R13]
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			delayed_bool_out <= `BLH_FLAG_RST;
		end else begin
			delayed_bool_out <= flag_nxt;
		end
	end

endmodule : blh_flag
`default_nettype wire

// [tb/blh_monitor.sv]
// Port checker for the Boolean holder
`timescale 1ns/1ps
`default_nettype none
`include "blh_defs.svh"
module blh_monitor
	import blh_pkg::*;
#(parameter int DATA_W = 32)(
	input wire logic       sys_clk,
	input wire logic       reset_n,
	input wire blh_cfg_t   cfg_in,
	input wire blh_data_t  capture_data_in,
	input wire blh_latch_t latch_in,
	input wire logic       retained_value_in,
	input wire logic       flag_in,
	input wire logic       bool_holder_out,
	input wire logic       retain_store_out,
	input wire logic       capture_strobe_out,
	input wire logic       holder_ready_out,
	input wire logic       delayed_bool_out
);
	logic lv, lp_r, db, cap, bv;
	blh_cfg_t c;
	assign c = cfg_in;
	// An open latch input reads as zero
	assign lv = latch_in.level & latch_in.connected;
	assign db = capture_data_in.is_float
		? |capture_data_in.value[`BLH_FLOAT_MAG_MSB:0]
		: |capture_data_in.value;
	assign bv = c.retain_en && (!c.new_download || c.init_from_retained)
		? retained_value_in : c.init_value;
	always_ff @(posedge sys_clk or negedge reset_n)
		if (!reset_n) lp_r <= 1'h0;
		else lp_r <= lv;
	always_comb begin
		case (c.mode)
		BLH_MODE_HIGH: cap = lv;
		BLH_MODE_LOW:  cap = !lv;
		BLH_MODE_RISE: cap = lv & !lp_r;
		BLH_MODE_FALL: cap = !lv & lp_r;
		BLH_MODE_BOTH: cap = lv ^ lp_r;
		default:       cap = 1'h0;
		endcase
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	AST_CAP_DATA: assert property (holder_ready_out && cap
		|=> bool_holder_out == $past(db)) else $error("bad captured bit");
	AST_CAP_STRB: assert property (holder_ready_out && cap
		|=> capture_strobe_out) else $error("strobe missing");
	AST_IDLE_STRB: assert property (!(holder_ready_out && cap)
		|=> !capture_strobe_out) else $error("stray strobe");
	AST_IDLE_HOLD: assert property (holder_ready_out && !cap
		|=> $stable(bool_holder_out)) else $error("bit changed idle");
	AST_BOOT: assert property (!holder_ready_out ##1 holder_ready_out
		|-> bool_holder_out == $past(bv)) else $error("bad boot bit");
	AST_FLAG: assert property (holder_ready_out
		|-> delayed_bool_out == $past(flag_in)) else $error("flag late");
	AST_RET_FREEZE: assert property (holder_ready_out && !c.retain_en
		|=> $stable(retain_store_out)) else $error("store moved");
	AST_RET_FOLLOW: assert property (holder_ready_out && c.retain_en
		|=> retain_store_out == bool_holder_out) else $error("store lags bit");
	AST_READY: assert property (holder_ready_out
		|=> holder_ready_out[*3]) else $error("ready dropped");
	cover property (cap && c.mode == BLH_MODE_RISE);
	cover property ($rose(holder_ready_out) && c.retain_en);
	cover property (cap && !latch_in.connected);
endmodule : blh_monitor
bind blh_bool_holder blh_monitor #(.DATA_W(DATA_W)) blh_monitor_i(
	.sys_clk, .reset_n, .cfg_in, .capture_data_in, .latch_in,
	.retained_value_in, .flag_in, .bool_holder_out, .retain_store_out,
	.capture_strobe_out, .holder_ready_out, .delayed_bool_out);
`default_nettype wire

// [tb/blh_nv_model.sv]
// Nonvolatile store beside the holder
`timescale 1ns/1ps
`default_nettype none
module blh_nv_model(
	input  wire logic sys_clk,
	input  wire logic ready_in,
	input  wire logic store_in,
	output var  logic value_out
);
	// Survives resets; written only while the holder runs
	always_ff @(posedge sys_clk) if (ready_in) value_out <= store_in;
endmodule : blh_nv_model
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the Boolean holder
`timescale 1ns/1ps
`default_nettype none
module tb;
	import blh_pkg::*;
	logic       sys_clk = 1'h0;
	logic       reset_n = 1'h0;
	logic       flag_in = 1'h0;
	logic       rv, bo, rs, st, rdy, dbo;
	blh_cfg_t   cfg_in = '0;
	blh_data_t  d_in = '0;
	blh_latch_t lt_in = '0;
	int         miscompares = 0;
	int         check_count = 0;
	int         cyc = 0;
	always #2.5 sys_clk = ~sys_clk;
	blh_bool_holder blh_bool_holder_i(.sys_clk, .reset_n, .cfg_in,
		.capture_data_in(d_in), .latch_in(lt_in), .retained_value_in(rv),
		.flag_in, .bool_holder_out(bo), .retain_store_out(rs),
		.capture_strobe_out(st), .holder_ready_out(rdy),
		.delayed_bool_out(dbo));
	blh_nv_model blh_nv_model_i(.sys_clk, .ready_in(rdy), .store_in(rs),
		.value_out(rv));
	task print_verdict();
		if (miscompares == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : print_verdict
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 400) begin
			miscompares++;
			print_verdict();
		end
	end
	task chk(string n, logic e, logic s);
		check_count++;
		if (s !== e) begin
			miscompares++;
			$display("[FAIL] %s exp %0h got %0h", n, e, s);
		end
	endtask : chk
	task boot(blh_cfg_t c, logic e);
		@(posedge sys_clk);
		cfg_in <= c;
		reset_n <= 1'h0;
		repeat (2) @(posedge sys_clk);
		reset_n <= 1'h1;
		@(posedge sys_clk);
		#1 chk("boot", e, bo);
		chk("ready", 1'h1, rdy);
		chk("strobe", 1'h0, st);
		if (c.retain_en) begin
			chk("store", e, rs);
		end
	endtask : boot
	task step(blh_mode_t m, blh_latch_t l, logic [31:0] v, logic f, logic e);
		@(posedge sys_clk);
		cfg_in.mode <= m;
		lt_in <= l;
		d_in <= {v, f};
		// User logic returns the stored bit through the flag
		flag_in <= bo;
		@(posedge sys_clk);
		#1 chk("bit", e, bo);
		chk("flag", flag_in, dbo);
	endtask : step
	task t_levels();
		step(BLH_MODE_HIGH, 2'h3, 32'h0, 1'h0, 1'h0);
		step(BLH_MODE_HIGH, 2'h1, 32'h13880, 1'h0, 1'h0);
		step(BLH_MODE_HIGH, 2'h3, 32'h13880, 1'h0, 1'h1);
		step(BLH_MODE_LOW, 2'h1, 32'h0, 1'h0, 1'h0);
		step(BLH_MODE_LOW, 2'h2, 32'hC2C5CCCD, 1'h1, 1'h1);
	endtask : t_levels
	task t_edges();
		step(BLH_MODE_RISE, 2'h1, 32'h0, 1'h0, 1'h1);
		step(BLH_MODE_RISE, 2'h3, 32'h0, 1'h0, 1'h0);
		step(BLH_MODE_RISE, 2'h3, 32'h1, 1'h0, 1'h0);
		step(BLH_MODE_FALL, 2'h1, 32'h1, 1'h0, 1'h1);
		step(BLH_MODE_FALL, 2'h3, 32'h0, 1'h0, 1'h1);
		step(BLH_MODE_BOTH, 2'h1, 32'h80000000, 1'h1, 1'h0);
		step(BLH_MODE_BOTH, 2'h3, 32'h3A83126F, 1'h1, 1'h1);
		step(BLH_MODE_BOTH, 2'h3, 32'h0, 1'h0, 1'h1);
	endtask : t_edges
	task t_strobe();
		@(posedge sys_clk);
		cfg_in.mode <= BLH_MODE_RISE;
		lt_in <= 2'h1;
		d_in <= {32'h0, 1'h0};
		@(posedge sys_clk);
		lt_in <= 2'h3;
		@(posedge sys_clk);
		#1 chk("strobe", 1'h1, st);
		chk("bit", 1'h0, bo);
		@(posedge sys_clk);
		#1 chk("strobe", 1'h0, st);
	endtask : t_strobe
	task t_retain();
		boot({BLH_MODE_HIGH, 4'h4}, 1'h0);
		step(BLH_MODE_HIGH, 2'h3, 32'h1, 1'h0, 1'h1);
		step(BLH_MODE_HIGH, 2'h1, 32'h0, 1'h0, 1'h1);
		boot({BLH_MODE_HIGH, 4'h4}, 1'h1);
		boot({BLH_MODE_HIGH, 4'h7}, 1'h1);
		boot({BLH_MODE_HIGH, 4'h6}, 1'h0);
	endtask : t_retain
	initial begin
		boot({BLH_MODE_HIGH, 4'h8}, 1'h1);
		t_levels();
		t_edges();
		t_strobe();
		t_retain();
		print_verdict();
	end
endmodule : tb
`default_nettype wire
